/* File: hw/dac_host_pkg.sv */
package dac_host_pkg;

  // --------------------------------------------------------------------------
  // Register map of the controller (byte addresses, one word each)
  // --------------------------------------------------------------------------
  localparam logic [3:0]  ctrl_off   = 4'h0;
  localparam logic [3:0]  data_off   = 4'h4;
  localparam logic [3:0]  cmd_off    = 4'h8;
  localparam logic [3:0]  status_off = 4'hc;

  // Field positions of the control register.
  localparam int ctrl_byte_mode_pos = 0;
  localparam int ctrl_sync_pos      = 1;
  localparam int ctrl_power_pos     = 2;

  // Field positions of the data register.
  localparam int data_gain_pos = 12;
  localparam int data_buf_pos  = 13;

  // Field positions of the command register.
  localparam int cmd_write_pos = 0;
  localparam int cmd_load_pos  = 1;
  localparam int cmd_clear_pos = 2;

  // Bus line positions of the settings during the high-byte write.
  localparam int hb_gain_line = 6;
  localparam int hb_buf_line  = 7;

  // --------------------------------------------------------------------------
  // Widths, reset values and timing
  // --------------------------------------------------------------------------
  localparam int dac_bits = 12;
  localparam int bus_bits = 16;
  localparam logic [2:0]  ctrl_reset = 3'h4;
  localparam logic [13:0] data_reset = 14'h0000;

  // Strobe phase width in ns, and cycles at 125 MHz (rounded up).
  localparam int clk_ps        = 8000;
  localparam int strobe_ns     = 40;
  localparam int strobe_cycles = (strobe_ns * 1000 + clk_ps - 1) / clk_ps;
  // Typical exit time from power-down at the low supply, in ns.
  localparam int wake_ns       = 5000;
  localparam int wake_cycles   = (wake_ns * 1000 + clk_ps - 1) / clk_ps;
  localparam int cnt_bits      = 10;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic                select_n;
    logic                write_n;
    logic                load_dac_n;
    logic                clear_all_n;
    logic                high_byte_select;
    logic                power_down_n;
    logic [bus_bits-1:0] bus;
  } pins_s;

  typedef enum logic [1:0] {op_none, op_low, op_high, op_word} wr_op_e;

endpackage : dac_host_pkg

/* File: hw/phase_timer.sv */
`timescale 1ns/1ps
module phase_timer
  import dac_host_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                start,
  input  wire logic [cnt_bits-1:0] length,
  output logic                     done
);

  logic [cnt_bits-1:0] cnt_q, cnt_d;
  logic                busy_q, busy_d;

  // Counts one strobe phase; done pulses as the phase ends.
  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done   = busy_q && (cnt_q == '0);
    if (start) begin
      cnt_d  = length - 1'b1;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cnt_q == '0) begin
        busy_d = 1'b0;
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
    end
  end

endmodule : phase_timer

/* File: hw/avalon_slave.sv */
`timescale 1ns/1ps
module avalon_slave
  import dac_host_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic        stall,
  input  wire logic [31:0] status_word,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic [2:0]       ctrl,
  output logic [13:0]      data,
  output logic [2:0]       cmd_pulse
);

  logic [31:0] readdata_q, readdata_d;
  logic [2:0]  ctrl_q, ctrl_d;
  logic [13:0] data_q, data_d;
  logic [2:0]  cmd_q, cmd_d;
  logic        ack_q, ack_d;
  logic        wait_q, wait_d;
  logic        take;

  // Each access waits one cycle; a command waits while the sequencer is busy.
  always_comb begin
    take       = (read || write) && !ack_q && !(write && address == cmd_off && stall);
    ack_d      = take;
    wait_d     = !take;
    readdata_d = readdata_q;
    ctrl_d     = ctrl_q;
    data_d     = data_q;
    cmd_d      = 3'h0;
    if (take && write) begin
      unique case (address)
        ctrl_off: ctrl_d = writedata[2:0];
        data_off: data_d = writedata[13:0];
        cmd_off:  cmd_d  = writedata[2:0];
        default:  ;
      endcase
    end
    if (take && read) begin
      unique case (address)
        ctrl_off:   readdata_d = {29'h0, ctrl_q};
        data_off:   readdata_d = {18'h0, data_q};
        status_off: readdata_d = status_word;
        default:    readdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      readdata_q <= 32'h0;
      ctrl_q     <= ctrl_reset;
      data_q     <= data_reset;
      cmd_q      <= 3'h0;
      ack_q      <= 1'b0;
      wait_q     <= 1'b1;
    end else begin
      readdata_q <= readdata_d;
      ctrl_q     <= ctrl_d;
      data_q     <= data_d;
      cmd_q      <= cmd_d;
      ack_q      <= ack_d;
      wait_q     <= wait_d;
    end
  end

  // Waitrequest has its own flop so the bus never sees an inverter output.
  assign readdata    = readdata_q;
  assign waitrequest = wait_q;
  assign ctrl        = ctrl_q;
  assign data        = data_q;
  assign cmd_pulse   = cmd_q;

endmodule : avalon_slave

/* File: hw/dac_host.sv */
// What this block does
// - Host holds select_n low and pulses write_n; data latched on rising edge.
// - high_byte_select 0 writes the low byte, 1 writes the high byte.
// - Word mode places buffer and gain on bus bits 13 and 12.
// - Byte mode writes low byte, then high byte with settings, then load if the command asks for it.
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module dac_host
  import dac_host_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output pins_s            pins
);

  // --------------------------------------------------------------------------
  // Register slave
  // --------------------------------------------------------------------------
  logic [2:0]  ctrl;
  logic [13:0] data;
  logic [2:0]  cmd;
  logic        busy;
  logic        pending_q, pending_d;
  logic        waking_q, waking_d;
  logic [31:0] status_word;

  assign status_word = {29'h0, waking_q, pending_q, busy};

  avalon_slave u_slave (
    .clk         (clk),
    .reset       (reset),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .stall       (busy),
    .status_word (status_word),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .ctrl        (ctrl),
    .data        (data),
    .cmd_pulse   (cmd)
  );

  // --------------------------------------------------------------------------
  // Strobe sequencer
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {st_idle, st_setup, st_strobe, st_hold, st_load, st_gap} state_e;

  state_e              state_q, state_d;
  wr_op_e              op_q, op_d;
  logic                do_load_q, do_load_d;
  pins_s               pins_q, pins_d;
  logic                t_start;
  logic [cnt_bits-1:0] t_len;
  logic                t_done;
  logic                w_start;
  logic                w_done;
  logic                byte_mode;
  logic                sync_mode;

  assign byte_mode = ctrl[ctrl_byte_mode_pos];
  assign sync_mode = ctrl[ctrl_sync_pos];
  assign busy      = (state_q != st_idle) || cmd[cmd_write_pos] || cmd[cmd_load_pos];

  phase_timer u_strobe_timer (
    .clk    (clk),
    .reset  (reset),
    .start  (t_start),
    .length (t_len),
    .done   (t_done)
  );

  // Wake timer; cnt_bits must cover wake_cycles, so widen both together.
  phase_timer u_wake_timer (
    .clk    (clk),
    .reset  (reset),
    .start  (w_start),
    .length (cnt_bits'(wake_cycles)),
    .done   (w_done)
  );

  // Drives the bus for one write: high byte carries settings on lines 6 and 7.
  function automatic logic [bus_bits-1:0] bus_word(input wr_op_e op, input logic [13:0] d);
    logic [bus_bits-1:0] w;
    w = '0;
    unique case (op)
      op_low:  w[7:0] = d[7:0];
      op_high: begin
        w[3:0]         = d[11:8];
        w[hb_gain_line] = d[data_gain_pos];
        w[hb_buf_line]  = d[data_buf_pos];
      end
      op_word: w = {2'b00, d};
      default: w = '0;
    endcase
    return w;
  endfunction

  // Sequencer next state; one write phase is setup, strobe low, hold.
  always_comb begin
    state_d   = state_q;
    op_d      = op_q;
    do_load_d = do_load_q;
    pins_d    = pins_q;
    pending_d = pending_q;
    waking_d  = waking_q;
    t_start   = 1'b0;
    t_len     = cnt_bits'(strobe_cycles);
    w_start   = 1'b0;
    pins_d.power_down_n = ctrl[ctrl_power_pos];
    if (ctrl[ctrl_power_pos] && !pins_q.power_down_n) begin
      w_start  = 1'b1;
      waking_d = 1'b1;
    end else if (w_done) begin
      waking_d = 1'b0;
    end
    pins_d.clear_all_n = !cmd[cmd_clear_pos];
    if (cmd[cmd_clear_pos]) begin
      pending_d = 1'b0;
    end
    unique case (state_q)
      st_idle: begin
        pins_d.load_dac_n = !sync_mode;
        if (cmd[cmd_write_pos]) begin
          op_d      = byte_mode ? op_low : op_word;
          do_load_d = cmd[cmd_load_pos];
          state_d   = st_setup;
          t_start   = 1'b1;
        end else if (cmd[cmd_load_pos]) begin
          state_d = st_load;
          t_start = 1'b1;
        end
      end
      st_setup: begin
        pins_d.select_n         = 1'b0;
        pins_d.high_byte_select = (op_q == op_high);
        pins_d.bus              = bus_word(op_q, data);
        if (t_done) begin
          pins_d.write_n = 1'b0;
          state_d        = st_strobe;
          t_start        = 1'b1;
        end
      end
      st_strobe: begin
        if (t_done) begin
          pins_d.write_n = 1'b1;
          state_d        = st_hold;
          t_start        = 1'b1;
        end
      end
      st_hold: begin
        if (t_done) begin
          pins_d.select_n = 1'b1;
          pending_d = !sync_mode;
          if (op_q == op_low) begin
            op_d    = op_high;
            state_d = st_setup;
            t_start = 1'b1;
          end else if (do_load_q && !sync_mode) begin
            state_d = st_load;
            t_start = 1'b1;
          end else begin
            state_d = st_gap;
            t_start = 1'b1;
          end
        end
      end
      st_load: begin
        pins_d.load_dac_n = 1'b0;
        if (t_done) begin
          pins_d.load_dac_n = !sync_mode;
          pending_d         = 1'b0;
          state_d           = st_gap;
          t_start           = 1'b1;
        end
      end
      st_gap: begin
        if (t_done) begin
          state_d = st_idle;
        end
      end
      default: state_d = st_idle;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q   <= st_idle;
      op_q      <= op_none;
      do_load_q <= 1'b0;
      pending_q <= 1'b0;
      waking_q  <= 1'b0;
      pins_q    <= '{select_n: 1'b1, write_n: 1'b1, load_dac_n: 1'b1, clear_all_n: 1'b1,
                     high_byte_select: 1'b0, power_down_n: 1'b1, bus: '0};
    end else begin
      state_q   <= state_d;
      op_q      <= op_d;
      do_load_q <= do_load_d;
      pending_q <= pending_d;
      waking_q  <= waking_d;
      pins_q    <= pins_d;
    end
  end

  assign pins = pins_q;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  // select covers strobe
  a_write_needs_select: assert property (@(posedge clk) disable iff (reset)
    !pins_q.write_n |-> !pins_q.select_n) else $error("write strobe without select");
  a_load_not_writing: assert property (@(posedge clk) disable iff (reset)
    (!pins_q.write_n && !sync_mode) |-> pins_q.load_dac_n) else $error("load during write");
  a_strobe_width: assert property (@(posedge clk) disable iff (reset)
    $fell(pins_q.write_n) |-> !pins_q.write_n [*5]) else $error("write strobe too short");
  a_high_line_zero: assert property (@(posedge clk) disable iff (reset)
    (!pins_q.select_n && pins_q.high_byte_select) |-> pins_q.bus[5:4] == 2'b00)
    else $error("high byte unused lines driven");
  a_byte_order: assert property (@(posedge clk) disable iff (reset)
    ($rose(pins_q.high_byte_select)) |-> $past(pins_q.write_n) && op_q == op_high)
    else $error("high byte out of order");
  a_power_follow: assert property (@(posedge clk) disable iff (reset)
    ##1 pins_q.power_down_n == $past(ctrl[ctrl_power_pos])) else $error("power pin lag");
  a_wake_flag: assert property (@(posedge clk) disable iff (reset)
    $rose(pins_q.power_down_n) |-> waking_q) else $error("wake not tracked");
  a_clear_pending: assert property (@(posedge clk) disable iff (reset)
    !pins_q.clear_all_n |-> !pending_q) else $error("pending after clear");
  a_select_leads: assert property (@(posedge clk) disable iff (reset)
    $fell(pins_q.write_n) |-> !$past(pins_q.select_n))
    else $error("write strobe without select setup");
  a_bus_steady: assert property (@(posedge clk) disable iff (reset)
    !pins_q.write_n |-> $stable(pins_q.bus) && $stable(pins_q.high_byte_select))
    else $error("bus moved during write strobe");
  a_clear_pulse: assert property (@(posedge clk) disable iff (reset)
    !pins_q.clear_all_n |=> pins_q.clear_all_n)
    else $error("clear held too long");
  // deferred load width; low from the cycle after entering the load state.
  a_load_width: assert property (@(posedge clk) disable iff (reset)
    ($fell(pins_q.load_dac_n) && state_q == st_load) |-> !pins_q.load_dac_n [*4])
    else $error("load strobe too short");
  a_sync_load_low: assert property (@(posedge clk) disable iff (reset)
    (sync_mode && $past(sync_mode) && !pins_q.write_n) |-> !pins_q.load_dac_n)
    else $error("load high during sync write");
  a_pending_set: assert property (@(posedge clk) disable iff (reset)
    $rose(pins_q.select_n) |-> pending_q == !$past(sync_mode))
    else $error("pending not set by write");
  a_load_clears: assert property (@(posedge clk) disable iff (reset)
    ($rose(pins_q.load_dac_n) && state_q == st_gap) |-> !pending_q)
    else $error("pending left after load");

endmodule : dac_host

/* File: dv/dac_device_model.sv */
`timescale 1ns/1ps
module dac_device_model
  import dac_host_pkg::*;
(
  input  wire pins_s           pins,
  input  wire logic            byte_mode,
  output logic [dac_bits-1:0]  in_code,
  output logic [dac_bits-1:0]  dac_code,
  output logic                 dac_gain,
  output logic                 dac_buf,
  output logic                 fresh,
  output logic                 out_on,
  output int                   n_updates
);
  logic in_gain;
  logic in_buf;

  // Moves the input register and its settings into the output path.
  task automatic update();
    dac_code = in_code;
    dac_gain = in_gain;
    dac_buf  = in_buf;
    fresh    = 1'b0;
    n_updates++;
  endtask : update

  initial begin
    in_code = '0; dac_code = '0; in_gain = 1'b0; in_buf = 1'b0;
    dac_gain = 1'b0; dac_buf = 1'b0; fresh = 1'b0; out_on = 1'b1; n_updates = 0;
  end

  always @(negedge pins.clear_all_n) begin
    in_code = '0; in_gain = 1'b0; in_buf = 1'b0;
    dac_code = '0; dac_gain = 1'b0; dac_buf = 1'b0; fresh = 1'b0;
  end

  always @(posedge pins.write_n) begin
    if (pins.clear_all_n && !pins.select_n) begin
      if (!byte_mode) begin
        in_code = pins.bus[dac_bits-1:0];
        in_gain = pins.bus[data_gain_pos];
        in_buf  = pins.bus[data_buf_pos];
      end else begin
        if (pins.high_byte_select) in_code[11:8] = pins.bus[3:0];
        else in_code[7:0] = pins.bus[7:0];
        in_gain = pins.bus[hb_gain_line];
        in_buf  = pins.bus[hb_buf_line];
      end
      fresh = 1'b1;
      if (!pins.load_dac_n) update();
    end
  end

  // transfer on load fall after a write, or at the write edge itself while load is held low
  always @(negedge pins.load_dac_n) begin
    if (pins.clear_all_n && fresh) update();
  end

  // output released while powered down; slow wake.
  always @(negedge pins.power_down_n) out_on = 1'b0;
  always @(posedge pins.power_down_n) out_on <= #2500 1'b1;
endmodule : dac_device_model

/* File: dv/tb_dac_host.sv */
`timescale 1ns/1ps
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH at %0t got %0h expected %0h", $time, (got), (exp)); end end
module tb_dac_host
  import dac_host_pkg::*;
();
  logic        clk;
  logic        reset;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  pins_s       pins;
  logic        byte_mode;
  logic [11:0] in_code;
  logic [11:0] dac_code;
  logic        dac_gain;
  logic        dac_buf;
  logic        fresh;
  logic        out_on;
  int          n_updates;
  int          error_cnt;
  int          n_compared;
  int          cycles;
  logic [15:0] lfsr;

  dac_host dac_host_i (.clk(clk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .pins(pins));

  dac_device_model dac_device_model_i (.pins(pins), .byte_mode(byte_mode),
    .in_code(in_code), .dac_code(dac_code), .dac_gain(dac_gain), .dac_buf(dac_buf),
    .fresh(fresh), .out_on(out_on), .n_updates(n_updates));

  // ---------------------------------------------------------------------------
  // Clock, timeout and verdict
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // A hang anywhere ends here rather than running forever.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  // ---------------------------------------------------------------------------
  // Bus tasks and expectations
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  function automatic logic [31:0] data_word(logic [11:0] c, logic g, logic b);
    return {18'h0, b, g, c};
  endfunction : data_word

  // Holds the request until waitrequest is seen low; the timeout bounds the wait.
  task automatic bus_access(input logic [3:0] a, input logic wr, input logic [31:0] d,
                            output logic [31:0] q);
    @(posedge clk);
    address   <= a;
    read      <= ~wr;
    write     <= wr;
    writedata <= d;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus_access

  task automatic run_cmd(input logic [2:0] c);
    logic [31:0] q;
    bus_access(cmd_off, 1'b1, {29'h0, c}, q);
    q = 32'h1;
    while (q[0] !== 1'b0) bus_access(status_off, 1'b0, 32'h0, q);
  endtask : run_cmd

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic [11:0] code;
    logic [11:0] prev;
    logic        g, b, bm, sy, pg;
    int          nu, t0;
    reset = 1'b1; address = 4'h0; read = 1'b0; write = 1'b0; writedata = 32'h0;
    byte_mode = 1'b0; error_cnt = 0; n_compared = 0; cycles = 0; lfsr = 16'd11082;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    bus_access(ctrl_off, 1'b0, 32'h0, q);
    `CHECK(q, {29'h0, ctrl_reset})
    bus_access(4'h2, 1'b1, 32'hffffffff, q);
    bus_access(4'h2, 1'b0, 32'h0, q);
    `CHECK(q, 32'h0)
    bus_access(data_off, 1'b0, 32'h0, q);
    `CHECK(q, 32'h0)
    `CHECK({dac_code, dac_gain, dac_buf}, 14'h0)
    `CHECK(pins.select_n, 1'b1)
    // Random words with corner codes first; deferred and immediate load modes.
    for (int i = 0; i < 24; i++) begin
      lfsr = lfsr_next(lfsr);
      {sy, bm, b, g, code} = lfsr;
      if (i < 4) begin
        code = i[0] ? 12'hfff : 12'h801; g = i[0]; b = ~i[0]; bm = i[1]; sy = 1'b0;
      end
      if (sy) bm = 1'b0;
      prev = dac_code; pg = dac_gain; nu = n_updates;
      byte_mode <= bm;
      bus_access(ctrl_off, 1'b1, {29'h0, 1'b1, sy, bm}, q);
      bus_access(data_off, 1'b1, data_word(code, g, b), q);
      bus_access(data_off, 1'b0, 32'h0, q);
      `CHECK(q, data_word(code, g, b))
      run_cmd(3'h1);
      if (sy) begin
        `CHECK(dac_code, code)
        `CHECK({dac_buf, dac_gain}, {b, g})
      end else begin
        `CHECK(dac_code, prev)
        `CHECK(dac_gain, pg)
        bus_access(status_off, 1'b0, 32'h0, q);
        `CHECK(q[1], 1'b1)
        run_cmd(3'h2);
        `CHECK(in_code, code)
        `CHECK(dac_code, code)
        `CHECK({dac_buf, dac_gain}, {b, g})
      end
      run_cmd(3'h2);
      `CHECK(n_updates, nu + 1)
    end
    // A clear between a write and its load leaves nothing to transfer.
    bus_access(ctrl_off, 1'b1, 32'h4, q);
    byte_mode <= 1'b0;
    bus_access(data_off, 1'b1, data_word(12'h5a5, 1'b1, 1'b1), q);
    run_cmd(3'h1);
    nu = n_updates;
    run_cmd(3'h4);
    `CHECK({in_code, dac_code, dac_gain, dac_buf}, 26'h0)
    run_cmd(3'h2);
    `CHECK(n_updates, nu)
    bus_access(data_off, 1'b1, data_word(12'h3c7, 1'b0, 1'b1), q);
    run_cmd(3'h3);
    // Power-down keeps register contents; wake takes the full wait.
    bus_access(ctrl_off, 1'b1, 32'h0, q);
    @(posedge clk);
    `CHECK(pins.power_down_n, 1'b0)
    `CHECK(out_on, 1'b0)
    bus_access(ctrl_off, 1'b1, 32'h4, q);
    t0 = cycles;
    bus_access(status_off, 1'b0, 32'h0, q);
    `CHECK(q[2], 1'b1)
    while (q[2] !== 1'b0) bus_access(status_off, 1'b0, 32'h0, q);
    `CHECK((cycles - t0) >= wake_cycles, 1'b1)
    `CHECK(out_on, 1'b1)
    `CHECK(dac_code, 12'h3c7)
    print_verdict();
  end
endmodule : tb_dac_host
